// ==== include/srad_pkg.sv ====
`default_nettype none
package srad_pkg;
    localparam int SRAD_FIFO_DEPTH = 4;
    localparam logic [5:0] SRAD_CNT_MAX = 6'h20;
    localparam logic [5:0] SRAD_ISR_CNT_RST = 6'h00;
    localparam logic [5:0] SRAD_OSR_CNT_RST = 6'h20;
    localparam logic [3:0] SRAD_ADR_CTRL = 4'h0;
    localparam logic [3:0] SRAD_ADR_STATUS = 4'h4;
    localparam logic [3:0] SRAD_ADR_OSR = 4'h8;
    localparam logic [3:0] SRAD_ADR_ISR = 4'hc;
    localparam int SRAD_REFILL_EN_BIT = 0;
    localparam int SRAD_DRAIN_EN_BIT = 1;
    localparam int SRAD_REFILL_THR_LSB = 8;
    localparam int SRAD_DRAIN_THR_LSB = 16;
    localparam int SRAD_RESTART_BIT = 31;
    localparam logic [31:0] SRAD_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SRAD_CTRL_WMASK = 32'h001f_1f03;
    localparam int SRAD_ST_OSR_LSB = 0;
    localparam int SRAD_ST_ISR_LSB = 8;
    localparam int SRAD_ST_TX_LSB = 16;
    localparam int SRAD_ST_RX_LSB = 24;
    typedef enum logic [2:0] {
        OP_NONE, OP_SHIFT_OUT, OP_SHIFT_IN, OP_FETCH,
        OP_COND_FETCH, OP_DEPOSIT, OP_COPY_OSR, OP_COPY_ISR
    } srad_op_t;
endpackage
`default_nettype wire

// ==== hw/srad_core.sv ====
// Summary of operation
// - Two saturating 6-bit counters track input and output register shift counts.
// - Reset or restart sets input count to 0, output count to 32.
// - Shift-out adds its bit count to the output count, saturating.
// - Shift-in adds its bit count to the input count, saturating.
// - Fetch or automatic refill loads output register from transmit FIFO, clears count.
// - Deposit or automatic drain clears the input count.
// - Copy into either shift register clears that register's count.
// - Shift-out into the input register sets its count to exactly n.
// - Refill and drain enabled separately; counts compared with their thresholds.
// - Drain at threshold stalls on full receive FIFO, else pushes and clears.
// - Shift, count, compare, push and clear of a drain finish in one cycle.
// - Refill and drain thresholds span 1 to 32 bits.
// - A threshold field of zero means 32 bits.
// - With engine enabled and no shift-out, refill from non-empty FIFO when count reaches threshold.
// - Shift-out with count at threshold stalls, refilling if data exists.
// - Otherwise shift-out shifts and counts, refilling same cycle at threshold.
// - With refill on, fetch is a no-op when full, else loads from the FIFO or stalls for data.
// - Conditional fetch judges emptiness with the refill threshold.
// - Copied output data is never overwritten by refill before shifting.
// - Side-set updates apply even while the instruction stalls.
// - Transmit and receive FIFOs are four words deep by default.
`timescale 1ns/1ps
`default_nettype none
module srad_core
    import srad_pkg::*;
#(
    parameter int DEPTH = SRAD_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wbCycI,
    input wire logic wbStbI,
    input wire logic wbWeI,
    input wire logic [3:0] wbAdrI,
    input wire logic [3:0] wbSelI,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAckO,
    input wire logic engineEn,
    input wire logic opValid,
    input wire srad_op_t opKind,
    input wire logic [5:0] opCount,
    input wire logic opOutToIsr,
    input wire logic [31:0] inData,
    input wire logic [31:0] copyData,
    input wire logic sideValid,
    input wire logic [4:0] sideData,
    output logic opDone,
    output logic opStall,
    output logic [31:0] outData,
    output logic outWrite,
    output logic sideWrite,
    output logic [4:0] sideOut,
    input wire logic txValid,
    input wire logic [31:0] txData,
    output logic txReady,
    output logic rxValid,
    output logic [31:0] rxData,
    input wire logic rxReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    logic [31:0] ctrl_reg, osr_reg, osr_next, isr_reg, isr_next, outData_reg, outData_next;
    logic [5:0] osrCnt_reg, osrCnt_next, isrCnt_reg, isrCnt_next;
    logic restart_reg, opDone_reg, opDone_next, opStall_reg, opStall_next;
    logic outWrite_reg, outWrite_next, sideWrite_reg, wbAck_reg, txReady_reg, rxValid_reg;
    logic [4:0] sideOut_reg;
    logic [31:0] wbDat_reg, rxData_reg, rxPushData;
    logic [31:0] txMem [DEPTH];
    logic [31:0] rxMem [DEPTH];
    logic [AW-1:0] txRdPtr_reg, txWrPtr_reg, rxRdPtr_reg, rxWrPtr_reg;
    logic [CW-1:0] txCnt_reg, rxCnt_reg;
    logic txPop, rxPush;
    // Threshold field decode, zero reads as a full word
    function automatic logic [5:0] thrDecode(input logic [4:0] f);
        return (f == 5'h00) ? SRAD_CNT_MAX : {1'b0, f};
    endfunction
    // Saturating count add
    function automatic logic [5:0] satAdd(input logic [5:0] a, input logic [5:0] b);
        logic [6:0] s;
        s = {1'b0, a} + {1'b0, b};
        return (s > {1'b0, SRAD_CNT_MAX}) ? SRAD_CNT_MAX : s[5:0];
    endfunction
    // Configuration decode
    wire refillEn = ctrl_reg[SRAD_REFILL_EN_BIT];
    wire drainEn = ctrl_reg[SRAD_DRAIN_EN_BIT];
    wire [4:0] refillFld = ctrl_reg[SRAD_REFILL_THR_LSB +: 5];
    wire [4:0] drainFld = ctrl_reg[SRAD_DRAIN_THR_LSB +: 5];
    wire [5:0] refillThr = thrDecode(refillFld);
    wire [5:0] drainThr = thrDecode(drainFld);
    // Operation datapath
    wire act = engineEn && opValid;
    wire [5:0] nEff = (opCount == 6'h00) ? SRAD_CNT_MAX : opCount;
    wire [5:0] maskShift = SRAD_CNT_MAX - nEff;
    wire [31:0] lowMask = 32'hffff_ffff >> maskShift;
    wire [31:0] outVal = osr_reg & lowMask;
    wire [31:0] osrShift = osr_reg >> nEff;
    wire [31:0] isrShift = (isr_reg << nEff) | (inData & lowMask);
    wire [5:0] osrSum = satAdd(osrCnt_reg, nEff);
    wire [5:0] isrSum = satAdd(isrCnt_reg, nEff);
    wire osrEmpty = osrCnt_reg >= refillThr;
    wire txNotEmpty = txCnt_reg != {CW{1'b0}};
    wire rxFull = rxCnt_reg == DEPTH_C;
    wire [31:0] txHead = txMem[txRdPtr_reg];
    wire isShiftOut = act && (opKind == OP_SHIFT_OUT);
    always_comb begin
        osr_next = osr_reg;
        osrCnt_next = osrCnt_reg;
        isr_next = isr_reg;
        isrCnt_next = isrCnt_reg;
        txPop = 1'b0;
        rxPush = 1'b0;
        rxPushData = isr_reg;
        opDone_next = 1'b0;
        opStall_next = 1'b0;
        outData_next = outData_reg;
        outWrite_next = 1'b0;
        if (restart_reg) begin
            osrCnt_next = SRAD_OSR_CNT_RST;
            isrCnt_next = SRAD_ISR_CNT_RST;
        end else begin
            if (act) begin
                unique case (opKind)
                    OP_NONE: begin
                    end
                    OP_SHIFT_OUT: begin
                        if (refillEn && osrEmpty) begin
                            opStall_next = 1'b1;
                            if (txNotEmpty) begin
                                txPop = 1'b1;
                                osr_next = txHead;
                                osrCnt_next = 6'h00;
                            end
                        end else begin
                            opDone_next = 1'b1;
                            outWrite_next = !opOutToIsr;
                            outData_next = outVal;
                            osr_next = osrShift;
                            osrCnt_next = osrSum;
                            if (opOutToIsr) begin
                                isr_next = outVal;
                                isrCnt_next = nEff;
                            end
                            if (refillEn && (osrSum >= refillThr) && txNotEmpty) begin
                                txPop = 1'b1;
                                osr_next = txHead;
                                osrCnt_next = 6'h00;
                            end
                        end
                    end
                    OP_SHIFT_IN: begin
                        if (drainEn && (isrSum >= drainThr)) begin
                            if (rxFull) begin
                                opStall_next = 1'b1;
                            end else begin
                                opDone_next = 1'b1;
                                rxPush = 1'b1;
                                rxPushData = isrShift;
                                isr_next = 32'h0000_0000;
                                isrCnt_next = 6'h00;
                            end
                        end else begin
                            opDone_next = 1'b1;
                            isr_next = isrShift;
                            isrCnt_next = isrSum;
                        end
                    end
                    OP_FETCH, OP_COND_FETCH: begin
                        if ((refillEn || opKind == OP_COND_FETCH) && !osrEmpty) begin
                            opDone_next = 1'b1;
                        end else if (txNotEmpty) begin
                            opDone_next = 1'b1;
                            txPop = 1'b1;
                            osr_next = txHead;
                            osrCnt_next = 6'h00;
                        end else begin
                            opStall_next = 1'b1;
                        end
                    end
                    OP_DEPOSIT: begin
                        if (rxFull) begin
                            opStall_next = 1'b1;
                        end else begin
                            opDone_next = 1'b1;
                            rxPush = 1'b1;
                            isr_next = 32'h0000_0000;
                            isrCnt_next = 6'h00;
                        end
                    end
                    OP_COPY_OSR: begin
                        opDone_next = 1'b1;
                        osr_next = copyData;
                        osrCnt_next = 6'h00;
                    end
                    OP_COPY_ISR: begin
                        opDone_next = 1'b1;
                        isr_next = copyData;
                        isrCnt_next = 6'h00;
                    end
                endcase
            end
            if (engineEn && refillEn && !isShiftOut && !txPop && txNotEmpty
                && (osrCnt_next >= refillThr)) begin
                txPop = 1'b1;
                osr_next = txHead;
                osrCnt_next = 6'h00;
            end
        end
    end
    // Transmit FIFO
    wire txWrite = txValid && txReady_reg;
    wire [CW-1:0] txCnt_next = txCnt_reg + CW'(txWrite) - CW'(txPop);
    wire [AW-1:0] txRdPtr_next = txRdPtr_reg + AW'(txPop);
    wire [AW-1:0] txWrPtr_next = txWrPtr_reg + AW'(txWrite);
    // Receive FIFO with registered head
    wire rxRead = rxReady && rxValid_reg;
    wire [CW-1:0] rxCnt_next = rxCnt_reg + CW'(rxPush) - CW'(rxRead);
    wire [AW-1:0] rxRdPtr_next = rxRdPtr_reg + AW'(rxRead);
    wire [AW-1:0] rxWrPtr_next = rxWrPtr_reg + AW'(rxPush);
    wire rxBypass = rxPush && (rxRdPtr_next == rxWrPtr_reg);
    wire [31:0] rxData_next = rxBypass ? rxPushData : rxMem[rxRdPtr_next];
    // Wishbone decode
    wire wbHit = wbCycI && wbStbI && !wbAck_reg;
    wire ctrlWr = wbHit && wbWeI && (wbAdrI == SRAD_ADR_CTRL);
    wire [31:0] laneMask = {{8{wbSelI[3]}}, {8{wbSelI[2]}}, {8{wbSelI[1]}}, {8{wbSelI[0]}}};
    wire [31:0] wrMask = laneMask & SRAD_CTRL_WMASK;
    wire [31:0] ctrl_next = ctrlWr ? ((ctrl_reg & ~wrMask) | (wbDatI & wrMask)) : ctrl_reg;
    wire restart_next = ctrlWr && wbSelI[3] && wbDatI[SRAD_RESTART_BIT];
    wire [31:0] statusWord = (32'(osrCnt_reg) << SRAD_ST_OSR_LSB)
        | (32'(isrCnt_reg) << SRAD_ST_ISR_LSB)
        | (32'(txCnt_reg) << SRAD_ST_TX_LSB)
        | (32'(rxCnt_reg) << SRAD_ST_RX_LSB);
    wire [31:0] rdData = (wbAdrI == SRAD_ADR_CTRL) ? ctrl_reg
        : (wbAdrI == SRAD_ADR_STATUS) ? statusWord
        : (wbAdrI == SRAD_ADR_OSR) ? osr_reg
        : (wbAdrI == SRAD_ADR_ISR) ? isr_reg : 32'h0000_0000;
    wire [31:0] wbDat_next = (wbHit && !wbWeI) ? rdData : 32'h0000_0000;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= SRAD_CTRL_RST;
            restart_reg <= 1'b0;
            wbAck_reg <= 1'b0;
            wbDat_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            restart_reg <= restart_next;
            wbAck_reg <= wbHit;
            wbDat_reg <= wbDat_next;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osr_reg <= 32'h0000_0000;
            isr_reg <= 32'h0000_0000;
            osrCnt_reg <= SRAD_OSR_CNT_RST;
            isrCnt_reg <= SRAD_ISR_CNT_RST;
            opDone_reg <= 1'b0;
            opStall_reg <= 1'b0;
            outData_reg <= 32'h0000_0000;
            outWrite_reg <= 1'b0;
        end else begin
            osr_reg <= osr_next;
            isr_reg <= isr_next;
            osrCnt_reg <= osrCnt_next;
            isrCnt_reg <= isrCnt_next;
            opDone_reg <= opDone_next;
            opStall_reg <= opStall_next;
            outData_reg <= outData_next;
            outWrite_reg <= outWrite_next;
        end
    end
    // Side-set passes through on every executed or stalled cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sideWrite_reg <= 1'b0;
            sideOut_reg <= 5'h00;
        end else begin
            sideWrite_reg <= act && sideValid;
            sideOut_reg <= (act && sideValid) ? sideData : sideOut_reg;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txRdPtr_reg <= '0;
            txWrPtr_reg <= '0;
            txCnt_reg <= '0;
            txReady_reg <= 1'b0;
            rxRdPtr_reg <= '0;
            rxWrPtr_reg <= '0;
            rxCnt_reg <= '0;
            rxValid_reg <= 1'b0;
            rxData_reg <= 32'h0000_0000;
        end else begin
            txRdPtr_reg <= txRdPtr_next;
            txWrPtr_reg <= txWrPtr_next;
            txCnt_reg <= txCnt_next;
            txReady_reg <= txCnt_next != DEPTH_C;
            rxRdPtr_reg <= rxRdPtr_next;
            rxWrPtr_reg <= rxWrPtr_next;
            rxCnt_reg <= rxCnt_next;
            rxValid_reg <= rxCnt_next != {CW{1'b0}};
            rxData_reg <= rxData_next;
        end
    end
    // FIFO storage, one write port each
    always_ff @(posedge clk) begin
        if (txWrite) begin
            txMem[txWrPtr_reg] <= txData;
        end
        if (rxPush) begin
            rxMem[rxWrPtr_reg] <= rxPushData;
        end
    end
    assign wbDatO = wbDat_reg;
    assign wbAckO = wbAck_reg;
    assign opDone = opDone_reg;
    assign opStall = opStall_reg;
    assign outData = outData_reg;
    assign outWrite = outWrite_reg;
    assign sideWrite = sideWrite_reg;
    assign sideOut = sideOut_reg;
    assign txReady = txReady_reg;
    assign rxValid = rxValid_reg;
    assign rxData = rxData_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_cnt_saturate: assert property (
        osrCnt_reg <= SRAD_CNT_MAX && isrCnt_reg <= SRAD_CNT_MAX
    ) else $error("shift count above 32");
    a_restart_init: assert property (
        restart_reg |=> osrCnt_reg == SRAD_OSR_CNT_RST && isrCnt_reg == SRAD_ISR_CNT_RST
    ) else $error("restart did not reinitialise counts");
    a_copy_clears: assert property (
        act && opKind == OP_COPY_OSR && !restart_reg
        |=> osrCnt_reg == 6'h00 && osr_reg == $past(copyData)
    ) else $error("copy to output register not kept");
    a_out_to_isr: assert property (
        isShiftOut && opOutToIsr && !opStall_next && !restart_reg
        |=> isrCnt_reg == $past(nEff) && opDone_reg
    ) else $error("shift into input register count wrong");
    a_drain_stall: assert property (
        act && opKind == OP_SHIFT_IN && drainEn && isrSum >= drainThr && rxFull && !restart_reg
        |=> opStall_reg && !opDone_reg && $stable(isr_reg)
    ) else $error("drain on full FIFO did not stall");
    a_no_fill_out: assert property (
        isShiftOut && refillEn && osrEmpty && !restart_reg
        |=> opStall_reg && !outWrite_reg
    ) else $error("refill and shift-out in same cycle");
    a_fetch_noop: assert property (
        act && opKind == OP_FETCH && refillEn && !osrEmpty && !restart_reg
        |=> opDone_reg && $stable(osr_reg) && $stable(txRdPtr_reg)
    ) else $error("fetch on full register not a no-op");
    a_sideset_stall: assert property (
        act && sideValid |=> sideWrite_reg && sideOut_reg == $past(sideData)
    ) else $error("side-set lost");
    a_wb_ack: assert property (
        wbCycI && wbStbI && !wbAckO |=> wbAckO ##1 !wbAckO
    ) else $error("bus answer not one cycle later");
endmodule // srad_core
`default_nettype wire

// ==== dv/srad_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module srad_host_model (
    input wire logic clk,
    input wire logic nrst,
    output logic txValid,
    output logic [31:0] txData,
    input wire logic txReady,
    input wire logic rxValid,
    input wire logic [31:0] rxData,
    output logic rxReady
);
    logic [31:0] txq[$];
    logic [31:0] rxq[$];
    logic rxHold = 1'b0;
    task automatic send(input logic [31:0] w);
        txq.push_back(w);
    endtask
    // Word held until taken; idle data toggles
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txValid <= 1'b0;
            txData <= 32'h0;
            rxReady <= 1'b0;
        end else begin
            if (txValid && txReady) begin
                void'(txq.pop_front());
            end
            txValid <= (txq.size() > 0);
            txData <= (txq.size() > 0) ? txq[0] : ~txData;
            if (rxValid && rxReady) begin
                rxq.push_back(rxData);
            end
            rxReady <= !rxHold;
        end
    end
endmodule // srad_host_model
`default_nettype wire

// ==== dv/shift_register_auto_refill_drain_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module shift_register_auto_refill_drain_tb_top import srad_pkg::*;;
    logic clk = 1'b0;
    logic nrst, wbCycI, wbStbI, wbWeI, wbAckO, engineEn, opValid, opOutToIsr, sideValid;
    logic opDone, opStall, outWrite, sideWrite, txValid, txReady, rxValid, rxReady;
    logic lastWr, lastSide;
    logic [3:0] wbAdrI, wbSelI;
    logic [31:0] wbDatI, wbDatO, inData, copyData, outData, txData, rxData, sd, lastOut, q;
    srad_op_t opKind;
    logic [5:0] opCount;
    logic [4:0] sideData, sideOut;
    int checks = 0;
    int miscompares = 0;
    int cycles = 0;
    logic [31:0] tw [6] = '{32'h8765_4321, 32'h1357_9bdf, 32'h2468_ace0, 32'hfedc_ba98,
        32'h0f1e_2d3c, 32'h5555_aaaa};

    always #12.5 clk = ~clk;

    srad_core #(.DEPTH(SRAD_FIFO_DEPTH)) u_dut (.clk(clk), .nrst(nrst),
        .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
        .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .engineEn(engineEn),
        .opValid(opValid), .opKind(opKind), .opCount(opCount), .opOutToIsr(opOutToIsr),
        .inData(inData), .copyData(copyData), .sideValid(sideValid), .sideData(sideData),
        .opDone(opDone), .opStall(opStall), .outData(outData), .outWrite(outWrite),
        .sideWrite(sideWrite), .sideOut(sideOut), .txValid(txValid), .txData(txData),
        .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady));

    srad_host_model u_host (.clk(clk), .nrst(nrst), .txValid(txValid), .txData(txData),
        .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady));

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        @(posedge clk);
        wbCycI <= 1'b1;
        wbStbI <= 1'b1;
        wbWeI <= we;
        wbAdrI <= a;
        wbDatI <= d;
        wbSelI <= 4'hf;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAckO !== 1'b1);
        chk("wbWait", n, 32'h2);
        r = wbDatO;
        wbCycI <= 1'b0;
        wbStbI <= 1'b0;
    endtask

    task automatic op(input srad_op_t k, input logic [5:0] n, input logic toIsr,
        input logic [31:0] d, input logic st);
        @(posedge clk);
        engineEn <= 1'b1;
        opValid <= 1'b1;
        opKind <= k;
        opCount <= n;
        opOutToIsr <= toIsr;
        inData <= d;
        copyData <= d;
        @(posedge clk);
        opValid <= 1'b0;
        @(posedge clk);
        chk("opStall", {31'h0, opStall}, {31'h0, st});
        chk("opDone", {31'h0, opDone}, {31'h0, !st});
        lastOut = outData;
        lastWr = outWrite;
        lastSide = sideWrite;
    endtask

    task automatic stat(input logic [5:0] o, input logic [5:0] i, input logic [2:0] t);
        wb(1'b0, SRAD_ADR_STATUS, 32'h0, sd);
        chk("osrCount", {26'h0, sd[5:0]}, {26'h0, o});
        chk("isrCount", {26'h0, sd[13:8]}, {26'h0, i});
        chk("txLevel", {29'h0, sd[18:16]}, {29'h0, t});
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        {wbCycI, wbStbI, wbWeI, opValid, opOutToIsr, sideValid} = 6'h00;
        engineEn = 1'b1;
        wbAdrI = 4'h0;
        wbSelI = 4'h0;
        {wbDatI, inData, copyData} = 96'h0;
        opKind = OP_NONE;
        opCount = 6'h00;
        sideData = 5'h00;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        stat(6'h20, 6'h00, 3'h0);
        wb(1'b0, 4'h2, 32'h0, q);
        chk("unmapped", q, 32'h0);
        for (int k = 0; k < 4; k++) begin
            u_host.send(tw[k]);
        end
        repeat (10) @(posedge clk);
        chk("txReady", {31'h0, txReady}, 32'h0);
        stat(6'h20, 6'h00, 3'h4);
        wb(1'b1, SRAD_ADR_CTRL, 32'h0000_0003, q);
        stat(6'h00, 6'h00, 3'h3);
        op(OP_SHIFT_OUT, 6'h08, 1'b0, 32'h0, 1'b0);
        chk("outData", lastOut, tw[0] & 32'h0000_00ff);
        chk("outWrite", {31'h0, lastWr}, 32'h1);
        stat(6'h08, 6'h00, 3'h3);
        op(OP_SHIFT_OUT, 6'h18, 1'b0, 32'h0, 1'b0);
        chk("outData", lastOut, tw[0] >> 8);
        stat(6'h00, 6'h00, 3'h2);
        for (int k = 1; k < 4; k++) begin
            op(OP_SHIFT_OUT, 6'h00, 1'b0, 32'h0, 1'b0);
            chk("outData", lastOut, tw[k]);
        end
        stat(6'h20, 6'h00, 3'h0);
        sideValid <= 1'b1;
        sideData <= 5'h15;
        op(OP_SHIFT_OUT, 6'h01, 1'b0, 32'h0, 1'b1);
        sideValid <= 1'b0;
        chk("sideWrite", {31'h0, lastSide}, 32'h1);
        chk("sideOut", {27'h0, sideOut}, 32'h15);
        engineEn <= 1'b0;
        u_host.send(tw[4]);
        repeat (4) @(posedge clk);
        op(OP_SHIFT_OUT, 6'h04, 1'b0, 32'h0, 1'b1);
        stat(6'h00, 6'h00, 3'h0);
        op(OP_SHIFT_OUT, 6'h04, 1'b0, 32'h0, 1'b0);
        chk("outData", lastOut, tw[4] & 32'h0000_000f);
        op(OP_FETCH, 6'h00, 1'b0, 32'h0, 1'b0);
        op(OP_COND_FETCH, 6'h00, 1'b0, 32'h0, 1'b0);
        stat(6'h04, 6'h00, 3'h0);
        wb(1'b1, SRAD_ADR_CTRL, 32'h0008_0003, q);
        wb(1'b0, SRAD_ADR_CTRL, 32'h0, q);
        chk("ctrl", q, 32'h0008_0003);
        u_host.rxHold <= 1'b1;
        op(OP_SHIFT_IN, 6'h04, 1'b0, 32'h0000_0005, 1'b0);
        stat(6'h04, 6'h04, 3'h0);
        op(OP_SHIFT_IN, 6'h04, 1'b0, 32'h0000_000a, 1'b0);
        stat(6'h04, 6'h00, 3'h0);
        for (int k = 0; k < 3; k++) begin
            op(OP_DEPOSIT, 6'h00, 1'b0, 32'h0, 1'b0);
        end
        op(OP_SHIFT_IN, 6'h04, 1'b0, 32'h0000_0003, 1'b0);
        op(OP_SHIFT_IN, 6'h04, 1'b0, 32'h0000_000c, 1'b1);
        stat(6'h04, 6'h04, 3'h0);
        chk("rxLevel", {29'h0, sd[26:24]}, 32'h4);
        u_host.rxHold <= 1'b0;
        repeat (10) @(posedge clk);
        op(OP_SHIFT_IN, 6'h04, 1'b0, 32'h0000_000c, 1'b0);
        repeat (6) @(posedge clk);
        chk("rxCount", 32'(u_host.rxq.size()), 32'h5);
        chk("rxHead", u_host.rxq[0], 32'h0000_005a);
        chk("rxLast", u_host.rxq[4], 32'h0000_003c);
        op(OP_SHIFT_OUT, 6'h05, 1'b1, 32'h0, 1'b0);
        chk("outWrite", {31'h0, lastWr}, 32'h0);
        stat(6'h09, 6'h05, 3'h0);
        wb(1'b1, SRAD_ADR_CTRL, 32'h0, q);
        for (int k = 0; k < 2; k++) begin
            op(OP_SHIFT_OUT, 6'h14, 1'b0, 32'h0, 1'b0);
            op(OP_SHIFT_IN, 6'h14, 1'b0, 32'h0, 1'b0);
        end
        stat(6'h20, 6'h20, 3'h0);
        wb(1'b1, SRAD_ADR_CTRL, 32'h0000_0001, q);
        op(OP_FETCH, 6'h00, 1'b0, 32'h0, 1'b1);
        op(OP_COND_FETCH, 6'h00, 1'b0, 32'h0, 1'b1);
        stat(6'h20, 6'h20, 3'h0);
        engineEn <= 1'b0;
        u_host.send(tw[5]);
        repeat (4) @(posedge clk);
        op(OP_COPY_OSR, 6'h00, 1'b0, 32'hc0de_f00d, 1'b0);
        op(OP_COPY_ISR, 6'h00, 1'b0, 32'hc0de_f00d, 1'b0);
        stat(6'h00, 6'h00, 3'h1);
        wb(1'b0, SRAD_ADR_OSR, 32'h0, q);
        chk("osr", q, 32'hc0de_f00d);
        wb(1'b0, SRAD_ADR_ISR, 32'h0, q);
        chk("isr", q, 32'hc0de_f00d);
        op(OP_SHIFT_IN, 6'h03, 1'b0, 32'h0000_0007, 1'b0);
        wb(1'b1, SRAD_ADR_CTRL, 32'h8000_0000, q);
        stat(6'h20, 6'h00, 3'h1);
        wb(1'b0, SRAD_ADR_CTRL, 32'h0, q);
        chk("ctrl", q, 32'h0);
        print_verdict();
    end
endmodule // shift_register_auto_refill_drain_tb_top
`default_nettype wire
